//--- tcu_defs.vh
// Constants for the 8-bit timer/counter compare unit
// Assumes inclusion by the design file only; no logic here
`ifndef TCU_DEFS_VH
`define TCU_DEFS_VH

// Register byte addresses on APB
`define TCU_ADDR_CNT   8'h00
`define TCU_ADDR_CMP   8'h04
`define TCU_ADDR_CTRL  8'h08
`define TCU_ADDR_FLAG  8'h0C
`define TCU_ADDR_MASK  8'h10
`define TCU_ADDR_ASYNC 8'h14

// Control register fields
`define TCU_CS_LSB     0
`define TCU_CS_MSB     2
`define TCU_WGM_LO     3
`define TCU_COM_LSB    4
`define TCU_COM_MSB    5
`define TCU_WGM_HI     6
`define TCU_FOC_BIT    7

// Flag and mask register bits
`define TCU_OVF_BIT    6
`define TCU_CMPF_BIT   7

// Waveform modes
`define TCU_WGM_NORMAL 2'h0
`define TCU_WGM_PCPWM  2'h1
`define TCU_WGM_CTC    2'h2
`define TCU_WGM_FAST   2'h3

// Compare output modes
`define TCU_COM_NONE   2'h0
`define TCU_COM_TOGGLE 2'h1
`define TCU_COM_CLEAR  2'h2
`define TCU_COM_SET    2'h3

// Counter extremes and reset values
`define TCU_BOTTOM     8'h00
`define TCU_MAX        8'hFF
`define TCU_ZERO8      8'h00
`define TCU_ZERO3      3'h0
`define TCU_ZERO10     10'h000

// Prescaler tap counts minus one
`define TCU_DIV8       10'h007
`define TCU_DIV32      10'h01F
`define TCU_DIV64      10'h03F
`define TCU_DIV128     10'h07F
`define TCU_DIV256     10'h0FF
`define TCU_DIV1024    10'h3FF

`endif

//--- tcu_timer8.v
// 8-bit timer/counter with one compare channel, reached over APB
// Assumes a single pclk domain; the crystal clock arrives as a pin level
// sampled synchronously, its rising edges becoming timer ticks.
//
// Functional notes
// (R1) Counter and compare value are eight-bit CPU-accessible registers.
// (R2) Timer clock is the I/O clock unless async select picks the crystal.
// (R3) Clock select zero stops the counter, holding its value.
// (R4) CPU reads and writes the counter at any time.
// (R5) CPU counter write beats clear, increment or decrement in that cycle.
// (R6) Bottom is 0x00, max 0xFF, top is 0xFF or the compare value.
// (R7) Each tick clears, increments or decrements, per waveform mode bits.
// (R8) Continuous compare; flag sets one tick after equality.
// (R9) Flag requests interrupt when enabled; clears on acknowledge or write one.
// (R10) Compare value double buffered in PWM modes, direct otherwise.
// (R11) Buffered value moves to the active register only at top or bottom.
// (R12) CPU compare accesses hit buffer when buffered, active register otherwise.
// (R13) Force strobe in non-PWM modes acts on output only, no flag, no clear.
// (R14) Counter write blocks compare matches on the next tick, even stopped.
// (R15) Software must not write bottom while counting down.
// (R16) Software sets output state before making the pin an output.
// (R17) Output state register keeps its value across mode changes.
// (R18) Compare output mode bits are unbuffered and act at once.
// (R19) Overflow flag set per mode and may request an interrupt.
// (R20) Both flags sit in the flag register, each masked in the mask register.
// (R21) Normal mode wraps max to zero, overflow set as counter hits zero.
// (R22) Mode 2 clears the counter when it equals the compare value.
// (R23) Fast PWM: non-inverting clears on match, sets at bottom; inverting reverse.
// (R24) Output mode zero takes no action on the output state at a match.
// (R25) Mode 1 is phase correct PWM, dual slope up to max and down.
//
// The APB slave port and the register offsets were left to the implementer.
`default_nettype none
`include "tcu_defs.vh"

module tcu_timer8 #(
  parameter PRESC_W = 10
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Crystal oscillator pins
  input  wire        crystal_pin_in,
  output reg         crystal_pin_out,
  // Compare output and interrupt requests
  output reg         compare_output,
  output reg         compare_irq,
  output reg         overflow_irq,
  // Interrupt acknowledges from the interrupt controller
  input  wire        compare_irq_ack,
  input  wire        overflow_irq_ack
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  reg [7:0]         timer_count_value_q;
  reg [7:0]         compare_value_reg_q;
  reg [7:0]         compare_buf_q;
  reg [7:0]         timer_control_reg_q;
  reg [7:0]         timer_mask_reg_q;
  reg               async_clock_select_q;
  reg               overflow_flag_q;
  reg               compare_flag_q;
  reg               match_pend_q;
  reg               block_q;
  reg               count_down_q;
  reg               osc_q;
  reg [PRESC_W-1:0] presc_q;

  wire [2:0] clock_select_field  = timer_control_reg_q[`TCU_CS_MSB:`TCU_CS_LSB];
  wire       waveform_mode_lo    = timer_control_reg_q[`TCU_WGM_LO];
  wire       waveform_mode_hi    = timer_control_reg_q[`TCU_WGM_HI];
  wire [1:0] waveform_mode_field = {waveform_mode_hi, waveform_mode_lo};
  wire [1:0] compare_output_mode = timer_control_reg_q[`TCU_COM_MSB:`TCU_COM_LSB];
  wire       pwm_mode            = waveform_mode_lo;

  ////////////////////////////////////////////////////////////////////////////
  // APB strobes; zero wait states
  wire acc    = psel & penable;
  wire wr     = acc & pwrite;
  wire wr_cnt = wr & (paddr == `TCU_ADDR_CNT);
  wire wr_cmp = wr & (paddr == `TCU_ADDR_CMP);
  wire wr_ctl = wr & (paddr == `TCU_ADDR_CTRL);
  wire wr_flg = wr & (paddr == `TCU_ADDR_FLAG);
  wire wr_msk = wr & (paddr == `TCU_ADDR_MASK);
  wire wr_asy = wr & (paddr == `TCU_ADDR_ASYNC);
  // Force uses the output and waveform mode written in the same word
  wire force_compare_strobe = wr_ctl & pwdata[`TCU_FOC_BIT] & ~pwdata[`TCU_WGM_LO];
  wire [1:0] com_now = wr_ctl ? pwdata[`TCU_COM_MSB:`TCU_COM_LSB] : compare_output_mode;

  // Mapped address check, used only by the error answer
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `TCU_ADDR_CNT) || (a == `TCU_ADDR_CMP) ||
               (a == `TCU_ADDR_CTRL) || (a == `TCU_ADDR_FLAG) ||
               (a == `TCU_ADDR_MASK) || (a == `TCU_ADDR_ASYNC);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timer clock: prescaled I/O clock or crystal edges
  // Crystal edge detection uses a registered copy; pins are taken as synchronous
  wire osc_rise = crystal_pin_in & ~osc_q;
  wire src_tick = async_clock_select_q ? osc_rise : 1'b1; // see (R2)
  reg  timer_clock;

  // Tap select is a function; only the tick uses its decode
  function tap_hit;
    input [2:0]         cs;
    input [PRESC_W-1:0] p;
    begin
      if (cs == 3'h1)
        tap_hit = 1'b1;
      else if (cs == 3'h2)
        tap_hit = ((p[9:0] & `TCU_DIV8) == `TCU_DIV8);
      else if (cs == 3'h3)
        tap_hit = ((p[9:0] & `TCU_DIV32) == `TCU_DIV32);
      else if (cs == 3'h4)
        tap_hit = ((p[9:0] & `TCU_DIV64) == `TCU_DIV64);
      else if (cs == 3'h5)
        tap_hit = ((p[9:0] & `TCU_DIV128) == `TCU_DIV128);
      else if (cs == 3'h6)
        tap_hit = ((p[9:0] & `TCU_DIV256) == `TCU_DIV256);
      else if (cs == 3'h7)
        tap_hit = (p[9:0] == `TCU_DIV1024);
      else
        tap_hit = 1'b0;
    end
  endfunction

  always @*
  begin
    timer_clock = src_tick & (clock_select_field != `TCU_ZERO3) // see (R3)
                  & tap_hit(clock_select_field, presc_q);
  end

  // Prescaler advances on each source tick
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_q         <= {PRESC_W{1'b0}};
      osc_q           <= 1'b0;
      crystal_pin_out <= 1'b0;
    end
    else
    begin
      osc_q           <= crystal_pin_in;
      crystal_pin_out <= ~crystal_pin_in; // Inverting oscillator stage
      if (src_tick)
        presc_q <= presc_q + {{(PRESC_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Top, bottom and match decode
  wire at_bottom = (timer_count_value_q == `TCU_BOTTOM); // see (R6)
  wire at_max    = (timer_count_value_q == `TCU_MAX);
  wire eq        = (timer_count_value_q == compare_value_reg_q); // see (R8)
  wire match     = eq & ~block_q; // see (R14)

  // Counter next value
  reg [7:0] cnt_d;
  reg       dir_d;
  reg       ovf_set;
  reg       upd_pt;
  always @*
  begin
    cnt_d   = timer_count_value_q;
    dir_d   = count_down_q;
    ovf_set = 1'b0;
    upd_pt  = 1'b0;
    case (waveform_mode_field) // see (R7)
      `TCU_WGM_NORMAL:
      begin
        cnt_d   = timer_count_value_q + 8'h01; // see (R21)
        ovf_set = at_max;
        dir_d   = 1'b0;
      end
      `TCU_WGM_CTC:
      begin
        dir_d = 1'b0;
        if (eq)
          cnt_d = `TCU_BOTTOM; // see (R22)
        else
          cnt_d = timer_count_value_q + 8'h01;
        ovf_set = at_max & ~eq;
      end
      `TCU_WGM_FAST:
      begin
        dir_d   = 1'b0;
        cnt_d   = timer_count_value_q + 8'h01;
        ovf_set = at_max; // see (R19)
        upd_pt  = at_max;
      end
      default:
      begin
        // Phase correct: reverse at max and at bottom
        if (at_max)
          dir_d = 1'b1;
        else if (at_bottom)
          dir_d = 1'b0;
        if (dir_d)
          cnt_d = timer_count_value_q - 8'h01; // see (R25)
        else
          cnt_d = timer_count_value_q + 8'h01;
        ovf_set = at_bottom;
        upd_pt  = at_max;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, compare registers and blocking
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_count_value_q <= `TCU_ZERO8;
      compare_value_reg_q <= `TCU_ZERO8;
      compare_buf_q       <= `TCU_ZERO8;
      count_down_q        <= 1'b0;
      block_q             <= 1'b0;
      match_pend_q        <= 1'b0;
    end
    else
    begin
      if (wr_cnt)
      begin
        timer_count_value_q <= pwdata[7:0]; // see (R4) see (R5)
        block_q             <= 1'b1; // see (R14)
      end
      else if (timer_clock)
      begin
        timer_count_value_q <= cnt_d;
        count_down_q        <= dir_d;
        block_q             <= 1'b0;
      end
      // Match seen now flags on the next tick
      if (timer_clock)
        match_pend_q <= match; // see (R8)
      if (wr_cmp & ~pwm_mode)
        compare_value_reg_q <= pwdata[7:0]; // see (R12)
      else if (pwm_mode & timer_clock & upd_pt)
        compare_value_reg_q <= compare_buf_q; // see (R10) see (R11)
      if (wr_cmp)
        compare_buf_q <= pwdata[7:0]; // see (R1)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output state; kept across mode changes, mode bits act at once
  reg oc_d;
  always @*
  begin
    oc_d = compare_output;
    if (pwm_mode & ~force_compare_strobe)
    begin
      // Phase correct: non-inverting clears on the way up, sets on the way down
      if (timer_clock & match & (compare_output_mode[1]))
        oc_d = (waveform_mode_hi ? compare_output_mode[0] // see (R23)
               : (compare_output_mode[0] ^ count_down_q));
      else if (timer_clock & waveform_mode_hi & at_max & compare_output_mode[1])
        oc_d = ~compare_output_mode[0];
    end
    else if ((timer_clock & match) | force_compare_strobe) // see (R13)
    begin
      case (com_now) // see (R18) see (R24)
        `TCU_COM_TOGGLE: oc_d = ~compare_output;
        `TCU_COM_CLEAR:  oc_d = 1'b0;
        `TCU_COM_SET:    oc_d = 1'b1;
        default:         oc_d = compare_output;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_output <= 1'b0;
    else
      compare_output <= oc_d; // see (R17)
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, mask and flags; hardware set wins over clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_reg_q  <= `TCU_ZERO8;
      timer_mask_reg_q     <= `TCU_ZERO8;
      async_clock_select_q <= 1'b0;
      overflow_flag_q      <= 1'b0;
      compare_flag_q       <= 1'b0;
      compare_irq          <= 1'b0;
      overflow_irq         <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        timer_control_reg_q <= {1'b0, pwdata[6:0]}; // Strobe bit not stored
      if (wr_msk)
        timer_mask_reg_q <= pwdata[7:0];
      if (wr_asy)
        async_clock_select_q <= pwdata[3];
      if (timer_clock & match_pend_q)
        compare_flag_q <= 1'b1; // see (R8)
      else if ((wr_flg & pwdata[`TCU_CMPF_BIT]) | compare_irq_ack)
        compare_flag_q <= 1'b0; // see (R9)
      if (timer_clock & ovf_set & ~wr_cnt)
        overflow_flag_q <= 1'b1; // see (R19)
      else if ((wr_flg & pwdata[`TCU_OVF_BIT]) | overflow_irq_ack)
        overflow_flag_q <= 1'b0;
      // Requests follow flag and mask one cycle behind
      compare_irq  <= compare_flag_q & timer_mask_reg_q[`TCU_CMPF_BIT]; // see (R20)
      overflow_irq <= overflow_flag_q & timer_mask_reg_q[`TCU_OVF_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data and answer
  reg [7:0] rd_d;
  always @*
  begin
    if (paddr == `TCU_ADDR_CNT)
      rd_d = timer_count_value_q;
    else if (paddr == `TCU_ADDR_CMP)
      rd_d = pwm_mode ? compare_buf_q : compare_value_reg_q;
    else if (paddr == `TCU_ADDR_CTRL)
      rd_d = timer_control_reg_q;
    else if (paddr == `TCU_ADDR_FLAG)
      rd_d = {compare_flag_q, overflow_flag_q, 6'h00};
    else if (paddr == `TCU_ADDR_MASK)
      rd_d = timer_mask_reg_q;
    else if (paddr == `TCU_ADDR_ASYNC)
      rd_d = {4'h0, async_clock_select_q, 3'h0};
    else
      rd_d = `TCU_ZERO8;
  end

  // pready rises at the edge that ends the setup cycle: zero wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      if (psel & ~penable & ~pwrite)
        prdata <= {24'h000000, rd_d};
    end
  end

endmodule // tcu_timer8

`default_nettype wire

//--- tcu_timer8_checker.sv
// Assertions on the APB port and crystal pins of the timer unit
// Assumes it is bound into tcu_timer8 with one pclk domain
`default_nettype none
module tcu_timer8_checker (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Crystal pins
  input wire logic        crystal_pin_in,
  input wire logic        crystal_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // All checks share pclk and sleep during reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // The two steps of one transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_setup_gets_access: assert property (s_setup |=> s_access)
    else $error("setup not answered");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_after_setup: assert property
    (pready |-> penable && $past(psel) && !$past(penable))
    else $error("ready outside access");
  a_idle_no_ready: assert property (!psel |=> !pready)
    else $error("ready while idle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_read_zero: assert property
    (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_read_upper_zero: assert property
    (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read upper bits set");
  // Low-cost check that the oscillator drive is the inverse of its input one cycle before
  a_xtal_inverse: assert property
    ($past(presetn) |-> crystal_pin_out == !$past(crystal_pin_in))
    else $error("crystal drive wrong");
endmodule // tcu_timer8_checker
bind tcu_timer8 tcu_timer8_checker tcu_timer8_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .crystal_pin_in(crystal_pin_in), .crystal_pin_out(crystal_pin_out));
`default_nettype wire

//--- tcu_tb.sv
// Self-checking bench for the 8-bit timer compare unit over APB
// Assumes tcu_timer8 and its bound checker are compiled before it
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // Bus, pins and bookkeeping
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, xout, cmp_out, cirq, oirq;
  logic        xin = 1'b0, cack = 1'b0, oack = 1'b0;
  logic [7:0]  rd;
  logic        er;
  int          fails = 0, n_compared = 0;
  // 50 MHz clock
  always #10 pclk = ~pclk;
  tcu_timer8 tcu_timer8_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_pin_in(xin), .crystal_pin_out(xout), .compare_output(cmp_out),
    .compare_irq(cirq), .overflow_irq(oirq), .compare_irq_ack(cack),
    .overflow_irq_ack(oack));
  ////////////////////////////////////////
  // Verdict, compares and bus cycles
  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_in(input logic [7:0] got, lo, hi, input string m);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      fails++;
      $display("BAD %0t %s got %h", $time, m, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until pready is seen at an edge, idle edge after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      $display("BAD %0t bus wait", $time);
      fails++;
      tally_and_finish;
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
    apb(1'b0, a, 8'h00);
    chk(rd, e, m);
  endtask
  // Polls the flag register; the timer keeps running meanwhile
  task automatic poll(input int b, input int lim);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, 8'h0C, 8'h00);
      k++;
    end
    while (rd[b] !== 1'b1 && k < lim);
    if (rd[b] !== 1'b1)
    begin
      $display("BAD %0t flag wait", $time);
      fails++;
      tally_and_finish;
    end
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rdc(8'h08, 8'h00, "ctl rst");
    rdc(8'h0C, 8'h00, "flg rst");
    rdc(8'h10, 8'h00, "msk rst");
    apb(1'b0, 8'h18, 8'h00);
    chk({7'h00, er}, 8'h01, "unmapped");
    wr(8'h00, 8'h55);
    cyc(20);
    rdc(8'h00, 8'h55, "stopped");
  endtask
  task automatic t_normal;
    wr(8'h10, 8'h40);
    wr(8'h08, 8'h01);
    wr(8'h00, 8'hF0);
    poll(6, 20);
    wr(8'h08, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk_in(rd, 8'h01, 8'h30, "wrap");
    chk({7'h00, oirq}, 8'h01, "ovf irq");
    wr(8'h10, 8'h00);
    cyc(2);
    chk({7'h00, oirq}, 8'h00, "ovf mask");
    wr(8'h0C, 8'h40);
    // Compare value is still zero, so the wrap through zero matched too
    rdc(8'h0C, 8'h80, "ovf w1c");
    wr(8'h0C, 8'h80);
  endtask
  task automatic t_ctc;
    wr(8'h04, 8'h10);
    rdc(8'h04, 8'h10, "cmp direct");
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h80);
    wr(8'h08, 8'h41);
    cyc(60);
    wr(8'h08, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk_in(rd, 8'h00, 8'h10, "ctc top");
    rdc(8'h0C, 8'h80, "cmp flag");
    chk({7'h00, cirq}, 8'h01, "cmp irq");
    // Acknowledge pulse from the interrupt controller
    cack <= 1'b1;
    @(posedge pclk);
    cack <= 1'b0;
    cyc(2);
    chk({7'h00, cirq}, 8'h00, "cmp ack");
    rdc(8'h0C, 8'h00, "ack clr");
  endtask
  task automatic t_block;
    wr(8'h04, 8'h20);
    wr(8'h00, 8'h20);
    wr(8'h08, 8'h01);
    cyc(8);
    wr(8'h08, 8'h00);
    rdc(8'h0C, 8'h00, "blocked");
    wr(8'h08, 8'h01);
    wr(8'h00, 8'h1F);
    cyc(4);
    wr(8'h08, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk_in(rd, 8'h21, 8'h2C, "cpu wins");
    rdc(8'h0C, 8'h80, "unblocked");
    wr(8'h0C, 8'h80);
  endtask
  // Output state is set by force before anything would use the pin
  task automatic t_force;
    logic [7:0] cw [5] = '{8'h90, 8'hB0, 8'h80, 8'hA0, 8'h90};
    logic [7:0] ex [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h01};
    wr(8'h00, 8'h33);
    foreach (cw[i])
    begin
      wr(8'h08, cw[i]);
      cyc(2);
      chk({7'h00, cmp_out}, ex[i], "force");
    end
    rdc(8'h0C, 8'h00, "force flg");
    rdc(8'h00, 8'h33, "force cnt");
    wr(8'h08, 8'h48);
    cyc(2);
    chk({7'h00, cmp_out}, 8'h01, "keep oc");
  endtask
  task automatic t_buffer;
    wr(8'h04, 8'h50);
    rdc(8'h04, 8'h50, "cmp buf");
    wr(8'h00, 8'h40);
    wr(8'h08, 8'h49);
    cyc(30);
    wr(8'h08, 8'h48);
    rdc(8'h0C, 8'h00, "buf held");
    wr(8'h08, 8'h49);
    poll(7, 200);
    wr(8'h08, 8'h08);
    wr(8'h0C, 8'hC0);
  endtask
  task automatic t_phase;
    // Written while stopped and never at bottom on a down slope
    wr(8'h00, 8'hF8);
    wr(8'h08, 8'h09);
    cyc(20);
    wr(8'h08, 8'h08);
    apb(1'b0, 8'h00, 8'h00);
    chk_in(rd, 8'hE0, 8'hFE, "dual slope");
  endtask
  // Non-inverting output in both PWM modes against compare value 0x50
  task automatic t_pwm;
    wr(8'h08, 8'h68);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h69);
    poll(7, 100);
    chk({7'h00, cmp_out}, 8'h00, "fast clr");
    poll(6, 100);
    chk({7'h00, cmp_out}, 8'h01, "fast set");
    wr(8'h0C, 8'hC0);
    wr(8'h08, 8'h29);
    poll(7, 100);
    chk({7'h00, cmp_out}, 8'h00, "up clr");
    wr(8'h0C, 8'h80);
    poll(7, 200);
    chk({7'h00, cmp_out}, 8'h01, "down set");
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'hC0);
  endtask
  task automatic t_xtal;
    wr(8'h08, 8'h00);
    wr(8'h14, 8'h08);
    rdc(8'h14, 8'h08, "async sel");
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h01);
    // Ten crystal periods, three pclk per half period
    repeat (10)
    begin
      xin <= 1'b1;
      cyc(3);
      xin <= 1'b0;
      cyc(3);
    end
    cyc(4);
    chk({7'h00, xout}, 8'h01, "xtal drive");
    wr(8'h08, 8'h00);
    rdc(8'h00, 8'h0A, "xtal ticks");
  endtask
  ////////////////////////////////////////
  // Reset for two cycles, then the scenarios
  initial
  begin
    cyc(2);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_normal;
    t_ctc;
    t_block;
    t_force;
    t_buffer;
    t_phase;
    t_pwm;
    t_xtal;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
